// [rtl/ufit_frame_timer.sv]
// Frame interval and frame remaining timing of a USB host controller core
`timescale 1ns/1ps
module ufit_frame_timer
    import ufit_pkg::*;
(
    // Clock and reset (one clock edge per bit time)
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire ufit_req_s         reg_req,
    output ufit_rsp_s              reg_rsp,
    // Controller state
    input  wire logic              operational_state,
    // Transaction budget
    input  wire logic              data_bit,
    input  wire logic [LP_W-1:0]   xact_bits,
    output logic                   xact_fits,
    output logic      [LP_W-1:0]   largest_packet_left,
    // Frame timing outputs
    output logic                   sof,
    output logic      [FN_W-1:0]   frame_number,
    output logic      [FI_W-1:0]   frame_remaining
);

    // ========================================================================
    // Decoding helpers
    // ========================================================================
    function automatic logic hit(input ufit_req_s r, input logic [7:0] ofs);
        hit = (r.addr == ofs);
    endfunction : hit

    // ========================================================================
    // Frame interval configuration register
    // ========================================================================
    logic [FI_W-1:0]  frame_interval;
    logic [LP_W-1:0]  largest_packet_bits;
    logic             interval_toggle;
    logic             wr_interval;
    logic             wr_remaining;

    assign wr_interval  = reg_req.wr && hit(reg_req, OFS_FRAME_INTERVAL_CONFIG);
    assign wr_remaining = reg_req.wr && hit(reg_req, OFS_FRAME_REMAINING_COUNTER);

    // Reserved bits are not stored and read as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_interval <= FI_NOMINAL;
        end else if (wr_interval) begin
            // Takes effect at the next reload; mid-frame trims are allowed
            frame_interval <= reg_req.wdata[FI_LSB +: FI_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            largest_packet_bits <= LP_RESET;
        end else if (wr_interval) begin
            largest_packet_bits <= reg_req.wdata[LP_LSB +: LP_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interval_toggle <= 1'b0;
        end else if (wr_interval) begin
            interval_toggle <= reg_req.wdata[TOGGLE_BIT];
        end
    end

    // ========================================================================
    // Operational entry detect
    // ========================================================================
    logic op_q;
    logic op_enter;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_q <= 1'b0;
        end else begin
            op_q <= operational_state;
        end
    end

    assign op_enter = operational_state && !op_q;

    // ========================================================================
    // Frame remaining counter
    // ========================================================================
    logic            fr_zero;
    logic            frame_reload;
    logic            fr_load;
    logic [FI_W-1:0] fr_load_value;
    logic            fr_dec;

    // Boundary reload wins over a software write in the same cycle
    assign frame_reload  = operational_state && op_q && fr_zero;
    assign fr_load       = frame_reload || op_enter || wr_remaining;
    assign fr_load_value = (frame_reload || op_enter) ? frame_interval
                                                      : reg_req.wdata[FI_LSB +: FI_W];
    assign fr_dec        = operational_state && op_q && !fr_zero;

    ufit_down_counter #(
        .W          (FI_W)
    ) u_remaining (
        .clk        (clk),
        .rst        (rst),
        .load       (fr_load),
        .load_value (fr_load_value),
        .dec        (fr_dec),
        .value      (frame_remaining),
        .zero       (fr_zero)
    );

    // ========================================================================
    // Remaining toggle
    // ========================================================================
    logic remaining_toggle;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remaining_toggle <= 1'b0;
        end else if (frame_reload) begin
            remaining_toggle <= interval_toggle;
        end else if (wr_remaining) begin
            remaining_toggle <= reg_req.wdata[TOGGLE_BIT];
        end
    end

    // ========================================================================
    // Frame number and start-of-frame pulse
    // ========================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_number <= FN_RESET;
        end else if (frame_reload || op_enter) begin
            frame_number <= frame_number + FN_W'(1);
        end
    end

    // Registered, so the pulse sits in the first bit time of the new frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sof <= 1'b0;
        end else begin
            sof <= frame_reload || op_enter;
        end
    end

    // ========================================================================
    // Largest data packet budget
    // ========================================================================
    logic lp_zero;

    ufit_down_counter #(
        .W          (LP_W)
    ) u_largest (
        .clk        (clk),
        .rst        (rst),
        .load       (frame_reload || op_enter),
        .load_value (largest_packet_bits),
        .dec        (data_bit && operational_state),
        .value      (largest_packet_left),
        .zero       (lp_zero)
    );

    // Budget check against the counter, not the register field
    assign xact_fits = !lp_zero && (xact_bits <= largest_packet_left);

    // ========================================================================
    // Read path
    // ========================================================================
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = RD_UNMAPPED;
        if (hit(reg_req, OFS_FRAME_INTERVAL_CONFIG)) begin
            next_rdata[FI_LSB +: FI_W] = frame_interval;
            next_rdata[LP_LSB +: LP_W] = largest_packet_bits;
            next_rdata[TOGGLE_BIT]     = interval_toggle;
        end else if (hit(reg_req, OFS_FRAME_REMAINING_COUNTER)) begin
            next_rdata[FI_LSB +: FI_W] = frame_remaining;
            next_rdata[TOGGLE_BIT]     = remaining_toggle;
        end
    end

    // Read data holds until the next read, so a late sample still sees it
    logic        rsp_valid;
    logic [31:0] rsp_rdata;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= reg_req.rd;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_rdata <= '0;
        end else if (reg_req.rd) begin
            rsp_rdata <= next_rdata;
        end
    end

    assign reg_rsp = '{valid: rsp_valid, rdata: rsp_rdata};

endmodule : ufit_frame_timer

// [rtl/ufit_pkg.sv]
// Constants, field layouts and carrier types of the frame interval timer
package ufit_pkg;

    // ========================================================================
    // Register map (byte offsets within the memory window)
    // ========================================================================
    localparam logic [7:0]  OFS_FRAME_INTERVAL_CONFIG  = 8'h34;
    localparam logic [7:0]  OFS_FRAME_REMAINING_COUNTER = 8'h38;

    // ========================================================================
    // Field widths and positions
    // ========================================================================
    localparam int          FI_W          = 14;
    localparam int          LP_W          = 15;
    localparam int          FN_W          = 14;
    localparam int          FI_LSB        = 0;
    localparam int          LP_LSB        = 16;
    localparam int          TOGGLE_BIT    = 31;

    // ========================================================================
    // Reset values and the read value of unmapped offsets
    // ========================================================================
    localparam logic [13:0] FI_NOMINAL    = 14'h2EDF;
    localparam logic [14:0] LP_RESET      = 15'h0000;
    localparam logic [13:0] FR_RESET      = 14'h0000;
    localparam logic [13:0] FN_RESET      = 14'h0000;
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

    // ========================================================================
    // Carrier types
    // ========================================================================
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ufit_req_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } ufit_rsp_s;

endpackage : ufit_pkg

// [rtl/ufit_down_counter.sv]
// Loadable down counter that stops at zero
`timescale 1ns/1ps
module ufit_down_counter #(
    parameter int W = 14
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         dec,
    // State
    output logic      [W-1:0] value,
    output logic              zero
);

    // ========================================================================
    // Counter; load beats decrement, no wrap below zero
    // ========================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= '0;
        end else if (load) begin
            value <= load_value;
        end else if (dec && (value != '0)) begin
            value <= value - W'(1);
        end
    end

    assign zero = (value == '0);

endmodule : ufit_down_counter

// [bench/ufit_frame_timer_asserts.sv]
// Port-level assertions of the frame interval timer
`timescale 1ns/1ps
module ufit_frame_timer_asserts
    import ufit_pkg::*;
(
    // Clock and reset
    input wire logic            clk,
    input wire logic            rst,
    // Observed ports
    input wire ufit_req_s       reg_req,
    input wire ufit_rsp_s       reg_rsp,
    input wire logic            operational_state,
    input wire logic            data_bit,
    input wire logic [LP_W-1:0] xact_bits,
    input wire logic            xact_fits,
    input wire logic [LP_W-1:0] largest_packet_left,
    input wire logic            sof,
    input wire logic [FN_W-1:0] frame_number,
    input wire logic [FI_W-1:0] frame_remaining
);
    // ========
    // Shadow of the interval register, so reload values are known
    logic [FI_W-1:0] fi_q;
    logic [LP_W-1:0] lp_q;
    logic            fit_q;
    logic            frt_q;
    logic            op_s;
    wire wr_fi = reg_req.wr && reg_req.addr == OFS_FRAME_INTERVAL_CONFIG;
    wire wr_fr = reg_req.wr && reg_req.addr == OFS_FRAME_REMAINING_COUNTER;
    wire rd_fi = reg_req.rd && reg_req.addr == OFS_FRAME_INTERVAL_CONFIG;
    wire rd_fr = reg_req.rd && reg_req.addr == OFS_FRAME_REMAINING_COUNTER;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fi_q  <= FI_NOMINAL;
            lp_q  <= LP_RESET;
            fit_q <= 1'b0;
        end else if (wr_fi) begin
            fi_q  <= reg_req.wdata[FI_LSB +: FI_W];
            lp_q  <= reg_req.wdata[LP_LSB +: LP_W];
            fit_q <= reg_req.wdata[TOGGLE_BIT];
        end
    end
    // Remaining toggle shadow; a boundary reload beats a software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_s  <= 1'b0;
            frt_q <= 1'b0;
        end else begin
            op_s <= operational_state;
            if (operational_state && op_s && frame_remaining == 14'h0000) begin
                frt_q <= fit_q;
            end else if (wr_fr) begin
                frt_q <= reg_req.wdata[TOGGLE_BIT];
            end
        end
    end
    // ========
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence run_s; operational_state && $past(operational_state); endsequence
    sequence end_s; run_s and frame_remaining == 14'h0000; endsequence
    sequence entry_s; operational_state && !$past(operational_state); endsequence
    frame_reload_a: assert property (end_s |=> sof && frame_remaining == $past(fi_q))
        else $error("Frame end without reload");
    entry_load_a: assert property (entry_s |=> sof && frame_remaining == $past(fi_q))
        else $error("Entry without reload");
    count_down_a: assert property (run_s and frame_remaining != 14'h0000 && !wr_fr
        |=> frame_remaining == $past(frame_remaining) - 14'h0001) else $error("No decrement");
    idle_hold_a: assert property (!operational_state && !wr_fr |=> $stable(frame_remaining) && !sof)
        else $error("Counting while idle");
    frame_step_a: assert property (frame_number == $past(frame_number) + {13'h0000, sof})
        else $error("Frame number step wrong");
    packet_load_a: assert property (sof |-> largest_packet_left == $past(lp_q))
        else $error("Packet budget not loaded");
    budget_fit_a: assert property (xact_fits == (largest_packet_left != 0 && xact_bits <= largest_packet_left))
        else $error("Fit flag wrong");
    read_answer_a: assert property (reg_rsp.valid == $past(reg_req.rd))
        else $error("Read answer timing wrong");
    interval_read_a: assert property (rd_fi |=> reg_rsp.rdata == {$past(fit_q), $past(lp_q), 2'h0, $past(fi_q)})
        else $error("Interval read wrong");
    remaining_read_a: assert property (rd_fr |=>
        reg_rsp.rdata == {$past(frt_q), 17'h0_0000, $past(frame_remaining)}) else $error("Remaining read wrong");
endmodule : ufit_frame_timer_asserts

// [bench/ufit_frame_timer_test.sv]
// Self-checking bench of the frame interval timer
`timescale 1ns/1ps
module ufit_frame_timer_test
    import ufit_pkg::*;
;
    logic        clk, rst, op, data_bit, xact_fits, sof;
    logic [14:0] xact_bits, lp_left;
    logic [13:0] fnum, frem;
    logic [31:0] d, s;
    ufit_req_s   req;
    ufit_rsp_s   rsp;
    int          failures, tests_run, cycles, seed, n, f, g, l, h;
    ufit_frame_timer i_dut (.clk(clk), .rst(rst), .reg_req(req), .reg_rsp(rsp), .operational_state(op),
        .data_bit(data_bit), .xact_bits(xact_bits), .xact_fits(xact_fits), .largest_packet_left(lp_left),
        .sof(sof), .frame_number(fnum), .frame_remaining(frem));
    // ========
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] w);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(negedge clk);
        req = '0;
        // Idle edge, so the next call never reassigns the request in this step
        @(negedge clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] r);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(negedge clk);
        req = '0;
        r = rsp.rdata;
        chk(rsp.valid, 1);
        @(negedge clk);
    endtask : reg_rd
    function automatic logic fits(int xb, int left);
        return left != 0 && xb <= left;
    endfunction : fits
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // ========
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end
    // ========
    // Main sequence
    initial begin
        seed = 84;
        rst       = 1'b1;
        op        = 1'b0;
        data_bit  = 1'b0;
        xact_bits = 15'h0000;
        req       = '0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        reg_rd(OFS_FRAME_INTERVAL_CONFIG, d);
        chk(d, {18'h0_0000, FI_NOMINAL});
        reg_rd(OFS_FRAME_REMAINING_COUNTER, d);
        chk(d, 32'h0000_0000);
        reg_rd(8'h3C, d);
        chk(d, RD_UNMAPPED);
        $display("Reset values done");
        f = 20 + ($random(seed) & 15);
        l = 1 + ($random(seed) & 7);
        // Reserved bits set on purpose: they must not be stored
        reg_wr(OFS_FRAME_INTERVAL_CONFIG, {1'b1, 15'(l), 2'h3, 14'(f)});
        reg_rd(OFS_FRAME_INTERVAL_CONFIG, d);
        chk(d, {1'b1, 15'(l), 2'h0, 14'(f)});
        op = 1'b1;
        @(negedge clk);
        chk(sof, 1);
        chk(frem, f);
        chk(fnum, 1);
        for (n = 1; n <= f + 1; n++) begin
            data_bit  = (n <= l + 1);
            xact_bits = 15'($random(seed) & 15);
            @(negedge clk);
            h = (n > f) ? l : (n >= l) ? 0 : l - n;
            chk(sof, n > f);
            chk(frem, (n > f) ? f : f - n);
            chk(lp_left, h);
            chk(xact_fits, fits(xact_bits, h));
        end
        data_bit = 1'b0;
        chk(fnum, 2);
        $display("First frame done");
        reg_rd(OFS_FRAME_REMAINING_COUNTER, d);
        chk(d, {1'b1, 17'h0_0000, 14'(f)});
        g = f + 1 + ($random(seed) & 7);
        reg_wr(OFS_FRAME_INTERVAL_CONFIG, {1'b0, 15'(l), 2'h0, 14'(g)});
        n = 0;
        while (sof !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(n, f - 3);
        chk(frem, g);
        chk(fnum, 3);
        reg_rd(OFS_FRAME_REMAINING_COUNTER, d);
        chk(d, {1'b0, 17'h0_0000, 14'(g)});
        $display("Interval change done");
        h = frem;
        op = 1'b0;
        repeat (3) @(negedge clk);
        chk(frem, h);
        op = 1'b1;
        @(negedge clk);
        chk(sof, 1);
        chk(frem, g);
        chk(fnum, 4);
        reg_rd(OFS_FRAME_INTERVAL_CONFIG, s);
        chk(s, {1'b0, 15'(l), 2'h0, 14'(g)});
        op = 1'b0;
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        reg_rd(OFS_FRAME_INTERVAL_CONFIG, d);
        chk(d, {18'h0_0000, FI_NOMINAL});
        chk(fnum, 0);
        reg_wr(OFS_FRAME_INTERVAL_CONFIG, s);
        reg_wr(8'h3C, 32'hFFFF_FFFF);
        reg_rd(OFS_FRAME_INTERVAL_CONFIG, d);
        chk(d, s);
        reg_wr(OFS_FRAME_REMAINING_COUNTER, {1'b1, 17'h1_FFFF, 14'(g)});
        reg_rd(OFS_FRAME_REMAINING_COUNTER, d);
        chk(d, {1'b1, 17'h0_0000, 14'(g)});
        $display("Re-entry and reset done");
        report_and_stop();
    end
endmodule : ufit_frame_timer_test
bind ufit_frame_timer ufit_frame_timer_asserts i_chk (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .operational_state(operational_state), .data_bit(data_bit), .xact_bits(xact_bits), .xact_fits(xact_fits),
    .largest_packet_left(largest_packet_left), .sof(sof), .frame_number(frame_number),
    .frame_remaining(frame_remaining));
